// File: core/ivw_pkg.sv
// Package for the interrupt vector and wakeup map.
// Assumes a CPU core that strobes its halt and wait instructions and takes a vector.
package ivw_pkg;
   localparam int IRQ_FIRST = 19;
   localparam int IRQ_LAST = 29;
   localparam int IRQ_COUNT = IRQ_LAST - IRQ_FIRST + 1;
   localparam logic [23:0] VECTOR_BASE = 24'h008054;
   localparam logic [23:0] VECTOR_STEP = 24'h000004;
   // Source index within the map (irq number minus 19)
   localparam int SRC_GTA_UPD = 0;
   localparam int SRC_GTA_CC = 1;
   localparam int SRC_GTB_UPD = 2;
   localparam int SRC_GTB_CC = 3;
   localparam int SRC_ADV_UPD = 4;
   localparam int SRC_ADV_CC = 5;
   localparam int SRC_BASIC = 6;
   localparam int SRC_SPI = 7;
   localparam int SRC_ASYNC_TX = 8;
   localparam int SRC_ASYNC_RX = 9;
   localparam int SRC_TWO_WIRE = 10;
   // Wakeup permission masks, bit n = source n
   localparam logic [10:0] WAKE_HALT_MASK = 11'h480;
   localparam logic [10:0] WAKE_WFI_MASK = 11'h7cf;
   localparam logic [10:0] WAKE_WFE_MASK = 11'h7ff;
   // Power modes reported to the core, one-hot
   typedef enum logic [4:0] {
      PM_RUN = 5'h01,
      PM_HALT = 5'h02,
      PM_ACTIVE_HALT = 5'h04,
      PM_WAIT_WFI = 5'h08,
      PM_WAIT_WFE = 5'h10
   } ivw_mode_type;
   localparam logic [4:0] RESET_MODE = 5'h01;
endpackage

// File: core/ivw_map.sv
// Interrupt vector map and low-power wakeup gating for IRQ 19 to 29.
// Assumes request lines already synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - IRQ 19..29 get vectors 0x8054 upward by four
// - SPI interrupt wakes from every low-power mode
// - Event-wait in low-power run enters low-power wait
// - Event-wait services enabled irq, then returns there
// - Wakeup-event source wakes core from event wait and resumes execution
// - Supply monitor ORed with selected port E/F line
// - Two-wire wakes from halt only on address match
module ivw_map (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Core instruction strobes and run state
   input wire logic wait_for_event_instr,
   input wire logic wait_for_interrupt_instr,
   input wire logic halt_instr,
   input wire logic active_halt_sel,
   input wire logic low_power_run,
   input wire logic handler_done,
   // Peripheral requests, bit n is irq 19+n
   input wire logic [ivw_pkg::IRQ_COUNT-1:0] irq_req,
   input wire logic [ivw_pkg::IRQ_COUNT-1:0] irq_enable,
   input wire logic [ivw_pkg::IRQ_COUNT-1:0] wake_event_sel,
   input wire logic two_wire_addr_match,
   // Shared external line sources
   input wire logic supply_voltage_monitor,
   input wire logic port_e_irq,
   input wire logic port_f_irq,
   input wire logic ext_irq_port_select_reg,
   // To the core
   output logic [4:0] power_mode,
   output logic low_power_wait,
   output logic wake,
   output logic resume,
   output logic irq_take,
   output logic [23:0] irq_vector,
   output logic shared_ext_irq
);
   import ivw_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic rst_meta;
   logic rst_sync_n;
   ivw_mode_type mode;
   ivw_mode_type next_mode;
   logic [IRQ_COUNT-1:0] eff_req;
   logic [IRQ_COUNT-1:0] allow;
   logic [IRQ_COUNT-1:0] hits;
   logic in_handler;
   logic next_take;
   logic [23:0] next_vector;
   logic next_resume;
   logic return_wfe;
   logic return_lpw;
   logic back_to_wfe;

   // Reset release synchroniser; all other logic runs from rst_sync_n
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Vector of a source index
   function automatic logic [23:0] vec_of(input int idx);
      vec_of = VECTOR_BASE + VECTOR_STEP * 24'(idx);
   endfunction

   // Lowest pending index wins
   function automatic logic [23:0] pick(input logic [IRQ_COUNT-1:0] v);
      pick = 24'h000000;
      for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
         if (v[i]) begin
            pick = vec_of(i);
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Request qualification per mode
   always_comb begin
      eff_req = irq_req;
      if (mode == PM_HALT || mode == PM_ACTIVE_HALT) begin
         eff_req[SRC_TWO_WIRE] = irq_req[SRC_TWO_WIRE] & two_wire_addr_match;
      end
      case (mode)
         PM_HALT, PM_ACTIVE_HALT: allow = WAKE_HALT_MASK;
         PM_WAIT_WFI: allow = WAKE_WFI_MASK;
         PM_WAIT_WFE: allow = WAKE_WFE_MASK;
         default: allow = {IRQ_COUNT{1'b1}};
      endcase
      hits = eff_req & allow & (irq_enable | wake_event_sel);
   end

   always_comb begin
      shared_ext_irq = supply_voltage_monitor |
         (ext_irq_port_select_reg ? port_f_irq : port_e_irq);
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode sequencing
   always_comb begin
      next_mode = mode;
      next_take = 1'b0;
      next_resume = 1'b0;
      next_vector = irq_vector;
      case (mode)
         PM_RUN: begin
            // Instructions are ignored and requests wait until the handler returns
            if (in_handler) begin
               next_mode = PM_RUN;
            end else if (wait_for_event_instr) begin
               next_mode = PM_WAIT_WFE;
            end else if (wait_for_interrupt_instr) begin
               next_mode = PM_WAIT_WFI;
            end else if (halt_instr) begin
               next_mode = active_halt_sel ? PM_ACTIVE_HALT : PM_HALT;
            end else if (|(irq_req & irq_enable)) begin
               next_take = 1'b1;
               next_vector = pick(irq_req & irq_enable);
            end
         end
         PM_WAIT_WFE: begin
            if (|(hits & wake_event_sel)) begin
               next_mode = PM_RUN;
               next_resume = 1'b1;
            end else if (|(hits & irq_enable)) begin
               next_mode = PM_RUN;
               next_take = 1'b1;
               next_vector = pick(hits & irq_enable);
            end
         end
         PM_HALT, PM_ACTIVE_HALT, PM_WAIT_WFI: begin
            // Only enabled interrupts end halt and interrupt wait
            if (|(hits & irq_enable)) begin
               next_mode = PM_RUN;
               next_take = 1'b1;
               next_vector = pick(hits & irq_enable);
            end
         end
         default: next_mode = PM_RUN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode register and handler bookkeeping
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mode <= PM_RUN;
      end else if (back_to_wfe) begin
         mode <= PM_WAIT_WFE;
      end else begin
         mode <= next_mode;
      end
   end

   // Handler finished and the core goes back to event wait
   always_comb begin
      back_to_wfe = handler_done && in_handler && return_wfe;
   end

   // Remember that the handler was entered from event wait
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         in_handler <= 1'b0;
         return_wfe <= 1'b0;
         return_lpw <= 1'b0;
      end else if (next_take) begin
         in_handler <= 1'b1;
         return_wfe <= (mode == PM_WAIT_WFE) && !(|(hits & wake_event_sel));
         return_lpw <= (mode == PM_WAIT_WFE) && low_power_wait;
      end else if (handler_done) begin
         in_handler <= 1'b0;
         return_wfe <= 1'b0;
         return_lpw <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs to the core
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_take <= 1'b0;
         irq_vector <= 24'h000000;
         resume <= 1'b0;
      end else begin
         irq_take <= next_take;
         irq_vector <= next_vector;
         resume <= next_resume;
      end
   end

   // Low power wait flag, restored when a handler returns to event wait
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         low_power_wait <= 1'b0;
      end else if (mode == PM_RUN && wait_for_event_instr && !in_handler) begin
         low_power_wait <= low_power_run;
      end else if (back_to_wfe) begin
         low_power_wait <= return_lpw;
      end else if (next_mode == PM_RUN) begin
         low_power_wait <= 1'b0;
      end
   end

   always_comb begin
      power_mode = mode;
      wake = (mode != PM_RUN) && (next_mode == PM_RUN);
   end
endmodule // ivw_map
`default_nettype wire

// File: tb/ivw_map_properties.sv
// Checker for the vector and wakeup map.
// Assumes it is bound to ivw_map.
`timescale 1ns/100ps
`default_nettype none
module ivw_map_properties (
   // Watched ports
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [10:0] irq_req,
   input wire logic [10:0] irq_enable,
   input wire logic [10:0] wake_event_sel,
   input wire logic two_wire_addr_match,
   input wire logic supply_voltage_monitor,
   input wire logic port_e_irq,
   input wire logic port_f_irq,
   input wire logic ext_irq_port_select_reg,
   input wire logic [4:0] power_mode,
   input wire logic low_power_wait,
   input wire logic wake,
   input wire logic resume,
   input wire logic irq_take,
   input wire logic [23:0] irq_vector,
   input wire logic shared_ext_irq
);
   wire logic [10:0] live = irq_req & (irq_enable | wake_event_sel);
   wire logic halted = power_mode == 5'h02 || power_mode == 5'h04;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_shared_or: assert property (shared_ext_irq ==
      (supply_voltage_monitor | (ext_irq_port_select_reg ? port_f_irq
      : port_e_irq))) else $error("shared line");
   chk_vec_map: assert property (irq_take |-> irq_vector[1:0] == 2'h0 &&
      irq_vector >= 24'h008054 && irq_vector <= 24'h00807c) else $error("vec");
   chk_wfe_enter: assert property ($rose(low_power_wait) |->
      power_mode == 5'h10) else $error("lp wait");
   chk_spi_wakes: assert property (power_mode != 5'h01 && live[7] &&
      (power_mode == 5'h10 || irq_enable[7]) |-> wake)
      else $error("spi wake");
   chk_halt_quiet: assert property (halted && !live[7] &&
      !(live[10] && two_wire_addr_match) |-> !wake) else $error("halt wake");
   chk_wfi_no_adv: assert property (power_mode == 5'h08 &&
      (live & 11'h7cf) == 11'h0 |-> !wake) else $error("wfi wake");
   chk_wfe_enabled: assert property (power_mode == 5'h10 &&
      live == 11'h0 |-> !wake) else $error("wfe wake");
   chk_event_resume: assert property (resume |-> power_mode == 5'h01 &&
      $past(power_mode) == 5'h10) else $error("resume");
   chk_wake_leaves: assert property (wake |=> (irq_take ^ resume)
      && power_mode == 5'h01) else $error("leave");
endmodule // ivw_map_properties
bind ivw_map ivw_map_properties u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .irq_req(irq_req),
   .irq_enable(irq_enable), .wake_event_sel(wake_event_sel),
   .two_wire_addr_match(two_wire_addr_match),
   .supply_voltage_monitor(supply_voltage_monitor),
   .port_e_irq(port_e_irq), .port_f_irq(port_f_irq),
   .ext_irq_port_select_reg(ext_irq_port_select_reg),
   .power_mode(power_mode), .low_power_wait(low_power_wait), .wake(wake),
   .resume(resume), .irq_take(irq_take), .irq_vector(irq_vector),
   .shared_ext_irq(shared_ext_irq)
);
`default_nettype wire

// File: tb/ivw_core_model.sv
// Core model: returns from each handler four cycles after the take.
// Assumes irq_take is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
module ivw_core_model (
   // Clock and handshake
   input wire logic core_clk,
   input wire logic irq_take,
   output logic handler_done
);
   logic [2:0] run = 3'h0;
   initial handler_done = 1'h0;
   always @(negedge core_clk) begin
      handler_done <= run[2];
      run <= {run[1:0], irq_take};
   end
endmodule // ivw_core_model
`default_nettype wire

// File: tb/irq_vector_wakeup_map_test.sv
// Testbench for the vector and wakeup map.
// Assumes the core model answers every take.
`timescale 1ns/100ps
`default_nettype none
module irq_vector_wakeup_map_test;
   logic core_clk = 0, rst_n = 0, wait_for_event_instr = 0, halt_instr = 0;
   logic wait_for_interrupt_instr = 0, active_halt_sel = 0, low_power_run = 0;
   logic two_wire_addr_match = 0, supply_voltage_monitor = 0, port_e_irq = 0;
   logic port_f_irq = 0, ext_irq_port_select_reg = 0;
   logic [10:0] irq_req = '0, irq_enable = '1, wake_event_sel = '0;
   logic handler_done, low_power_wait, wake, resume, irq_take, shared_ext_irq;
   logic [4:0] power_mode;
   logic [23:0] irq_vector;
   int mismatches = 0, check_count = 0;
   ivw_map u_dut (
      .core_clk(core_clk), .rst_n(rst_n),
      .wait_for_event_instr(wait_for_event_instr),
      .wait_for_interrupt_instr(wait_for_interrupt_instr),
      .halt_instr(halt_instr), .active_halt_sel(active_halt_sel),
      .low_power_run(low_power_run), .handler_done(handler_done),
      .irq_req(irq_req), .irq_enable(irq_enable),
      .wake_event_sel(wake_event_sel),
      .two_wire_addr_match(two_wire_addr_match),
      .supply_voltage_monitor(supply_voltage_monitor),
      .port_e_irq(port_e_irq), .port_f_irq(port_f_irq),
      .ext_irq_port_select_reg(ext_irq_port_select_reg),
      .power_mode(power_mode), .low_power_wait(low_power_wait),
      .wake(wake), .resume(resume), .irq_take(irq_take),
      .irq_vector(irq_vector), .shared_ext_irq(shared_ext_irq)
   );
   ivw_core_model u_core (
      .core_clk(core_clk), .irq_take(irq_take),
      .handler_done(handler_done)
   );
   always #12.5 core_clk = ~core_clk;
   task automatic chk(input logic [23:0] got, exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      tick(1);
      s = 0;
   endtask
   task automatic wait_on(ref logic s);
      int i;
      for (i = 0; i < 40 && s !== 1'h1; i++) tick(1);
      if (i == 40) begin
         mismatches++;
         tally_and_finish;
      end
   endtask
   task automatic t_vectors;
      for (int n = 0; n < 12; n++) begin
         irq_req = (n == 11) ? 11'h600 : 11'h1 << n;
         wait_on(irq_take);
         chk(irq_vector, 24'h008054 + 24'(4 * (n == 11 ? 9 : n)));
         irq_req = '0;
         tick(8);
      end
      $display("vectors done");
   endtask
   task automatic t_wfe;
      low_power_run = 1;
      irq_enable = 11'h080;
      pulse(wait_for_event_instr);
      irq_req = 11'h001;
      tick(4);
      chk(24'({low_power_wait, power_mode}), 24'h30);
      irq_req = 11'h081;
      wait_on(irq_take);
      chk(irq_vector, 24'h008070);
      irq_req = '0;
      tick(8);
      chk(24'({low_power_wait, power_mode}), 24'h30);
      wake_event_sel = 11'h001;
      irq_req = 11'h001;
      wait_on(resume);
      chk(24'(power_mode), 24'h01);
      {irq_req, wake_event_sel, low_power_run} = '0;
      tick(6);
      chk(24'(power_mode), 24'h01);
      $display("wfe done");
   endtask
   task automatic t_sleep;
      irq_enable = '1;
      pulse(halt_instr);
      irq_req = 11'h37f;
      tick(4);
      chk(24'({wake, power_mode}), 24'h02);
      irq_req = 11'h400;
      tick(4);
      chk(24'(power_mode), 24'h02);
      two_wire_addr_match = 1;
      wait_on(irq_take);
      chk(irq_vector, 24'h00807c);
      irq_req = '0;
      tick(8);
      active_halt_sel = 1;
      pulse(halt_instr);
      chk(24'(power_mode), 24'h04);
      irq_req = 11'h080;
      #1;
      chk(24'(wake), 24'h1);
      wait_on(irq_take);
      chk(irq_vector, 24'h008070);
      irq_req = '0;
      tick(8);
      pulse(wait_for_interrupt_instr);
      irq_req = 11'h030;
      tick(4);
      chk(24'(power_mode), 24'h08);
      irq_req = 11'h031;
      wait_on(irq_take);
      chk(irq_vector, 24'h008054);
      irq_req = '0;
      tick(8);
      $display("sleep done");
   endtask
   task automatic t_shared;
      for (int k = 0; k < 16; k++) begin
         {supply_voltage_monitor, port_e_irq, port_f_irq,
            ext_irq_port_select_reg} = 4'(k);
         tick(1);
         chk(24'(shared_ext_irq), 24'(k[3] | (k[0] ? k[1] : k[2])));
      end
      $display("shared done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      tick(6);
      rst_n = 1;
      tick(4);
      t_vectors;
      t_wfe;
      t_sleep;
      t_shared;
      tally_and_finish;
   end
endmodule // irq_vector_wakeup_map_test
`default_nettype wire
